// ### rtl/tpwm_pkg.sv
// Constants, field layouts and state type of the triggered PWM timer
package tpwm_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] ADDR_CTL0 = 8'h00;
  localparam logic [7:0] ADDR_CTL1 = 8'h04;
  localparam logic [7:0] ADDR_IOC0 = 8'h08;
  localparam logic [7:0] ADDR_IOC2 = 8'h0c;
  localparam logic [7:0] ADDR_CNT = 8'h10;
  localparam logic [7:0] ADDR_CCR0 = 8'h14;
  localparam logic [7:0] ADDR_CCR1 = 8'h18;
  // Field positions
  localparam int CTL0_CE_BIT = 7;
  localparam int CTL1_EST_BIT = 6;
  localparam int CTL1_EEE_BIT = 5;
  localparam int IOC0_OL1_BIT = 3;
  localparam int IOC0_OE1_BIT = 2;
  localparam int IOC0_OL0_BIT = 1;
  localparam int IOC0_OE0_BIT = 0;
  // Encodings and fixed values
  localparam logic [2:0] MODE_EXT_TRIG = 3'h2;
  localparam logic [15:0] CNT_IDLE = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Reset values of the software registers
  localparam logic [15:0] CCR_RST = 16'h0000;
  localparam logic [3:0] IOC_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } run_state_t;

  typedef struct packed {
    run_state_t st;
    logic [15:0] cnt;
    logic [15:0] buf0;
    logic [15:0] buf1;
    logic [15:0] ccr0;
    logic [15:0] ccr1;
    logic ce;
    logic [2:0] cks;
    logic eee;
    logic [2:0] mode;
    logic [3:0] ioc0;
    logic [3:0] ioc2;
    logic arm;
    logic sw_trig;
    logic [6:0] presc;
    logic [2:0] trig_sync;
    logic [2:0] evt_sync;
    logic sq;
    logic sq_pin;
    logic pwm_pin;
    logic irq0;
    logic irq1;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;

  localparam state_t STATE_RST = '{st: ST_STOP, cnt: CNT_IDLE,
    buf0: CCR_RST, buf1: CCR_RST, ccr0: CCR_RST, ccr1: CCR_RST,
    ioc0: IOC_RST, ioc2: IOC_RST, default: '0};
endpackage

// ### rtl/triggered_pwm_timer.sv
// Triggered PWM timer channel with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module triggered_pwm_timer
  import tpwm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trigger_in,
  input wire logic event_in,
  output logic pwm_output,
  output logic square_wave_output,
  output logic period_match_irq,
  output logic width_match_irq
);

  state_t s_ff;
  state_t nxt_s;

  // Edge detect: 00 none, 01 rising, 10 falling, 11 both
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic now, input logic prev);
    edge_hit = (sel[0] & now & ~prev) | (sel[1] & ~now & prev);
  endfunction

  // Prescaler tap: divide by two to the power of the select field
  function automatic logic presc_hit(input logic [6:0] cnt,
                                     input logic [2:0] sel);
    logic [6:0] mask;
    mask = 7'((8'h01 << sel) - 8'h01);
    presc_hit = ((cnt & mask) == mask);
  endfunction

  // Byte-lane merge for narrow registers
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    lane_merge[7:0] = strb[0] ? data[7:0] : old[7:0];
    lane_merge[15:8] = strb[1] ? data[15:8] : old[15:8];
  endfunction

  logic trig;
  logic tick;
  logic mode_ok;
  logic moved;
  logic reload;
  logic [7:0] rd_addr;

  // Handshake outputs straight from the holding flags
  assign s_axi_awready = ~s_ff.aw_got & ~s_ff.bvalid;
  assign s_axi_wready = ~s_ff.w_got & ~s_ff.bvalid;
  assign s_axi_arready = ~s_ff.rvalid;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rresp = s_ff.rresp;
  assign s_axi_rdata = s_ff.rdata;
  assign pwm_output = s_ff.pwm_pin;
  assign square_wave_output = s_ff.sq_pin;
  assign period_match_irq = s_ff.irq0;
  assign width_match_irq = s_ff.irq1;

  // Next-state logic for timer engine and bus slave
  always_comb begin
    nxt_s = s_ff;
    moved = 1'b0;
    reload = 1'b0;
    rd_addr = s_axi_araddr;
    nxt_s.irq0 = 1'b0;
    nxt_s.irq1 = 1'b0;
    nxt_s.sw_trig = 1'b0;
    // Only the second stage and later of each synchroniser feed logic
    nxt_s.trig_sync = {s_ff.trig_sync[1:0], trigger_in};
    nxt_s.evt_sync = {s_ff.evt_sync[1:0], event_in};
    nxt_s.presc = s_ff.presc + 7'h01;
    trig = s_ff.sw_trig |
           edge_hit(s_ff.ioc2[1:0], s_ff.trig_sync[1],
                    s_ff.trig_sync[2]);
    tick = s_ff.eee ?
           edge_hit(s_ff.ioc2[3:2], s_ff.evt_sync[1], s_ff.evt_sync[2]) :
           presc_hit(s_ff.presc, s_ff.cks);
    mode_ok = s_ff.ce & (s_ff.mode == MODE_EXT_TRIG);

    // Counter sequencing; a trigger outranks a same-cycle match
    case (s_ff.st)
      ST_STOP: begin
        nxt_s.cnt = CNT_IDLE;
        nxt_s.sq = s_ff.ioc0[IOC0_OL0_BIT];
        if (mode_ok) begin
          nxt_s.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!mode_ok) begin
          nxt_s.st = ST_STOP;
        end else if (trig) begin
          nxt_s.st = ST_RUN;
          nxt_s.cnt = CNT_ZERO;
          nxt_s.buf0 = s_ff.ccr0;
          nxt_s.buf1 = s_ff.ccr1;
          nxt_s.sq = ~s_ff.sq;
          moved = 1'b1;
        end
      end
      ST_RUN: begin
        if (!mode_ok) begin
          nxt_s.st = ST_STOP;
          nxt_s.cnt = CNT_IDLE;
        end else if (trig) begin
          nxt_s.cnt = CNT_ZERO;
          nxt_s.sq = ~s_ff.sq;
          moved = 1'b1;
        end else if (tick) begin
          moved = 1'b1;
          if (s_ff.cnt == s_ff.buf0) begin
            nxt_s.cnt = CNT_ZERO;
            nxt_s.irq0 = 1'b1;
            nxt_s.sq = ~s_ff.sq;
            reload = s_ff.arm;
          end else begin
            nxt_s.cnt = s_ff.cnt + 16'h0001;
          end
        end
      end
      default: begin
        nxt_s.st = ST_STOP;
        nxt_s.cnt = CNT_IDLE;
      end
    endcase

    // Buffered compare values change only here and at the first trigger, so a mid-cycle write
    // cannot tear the period or width in flight
    if (reload) begin
      nxt_s.buf0 = s_ff.ccr0;
      nxt_s.buf1 = s_ff.ccr1;
      nxt_s.arm = 1'b0;
    end

    // Width pulse in the cycle the counter lands on the buffer
    nxt_s.irq1 = (nxt_s.st == ST_RUN) & moved &
                 (nxt_s.cnt == nxt_s.buf1);

    // Write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = s_axi_wdata;
      nxt_s.wstrb = s_axi_wstrb;
    end
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end

    // Register write once both halves are held
    if (s_ff.aw_got && s_ff.w_got) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = RESP_OKAY;
      case (s_ff.awaddr)
        ADDR_CTL0: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.ce = s_ff.wdata[CTL0_CE_BIT];
            nxt_s.cks = s_ff.wdata[2:0];
          end
        end
        ADDR_CTL1: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.sw_trig = s_ff.wdata[CTL1_EST_BIT];
            nxt_s.eee = s_ff.wdata[CTL1_EEE_BIT];
            nxt_s.mode = s_ff.wdata[2:0];
          end
        end
        ADDR_IOC0: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.ioc0 = s_ff.wdata[3:0];
          end
        end
        ADDR_IOC2: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.ioc2 = s_ff.wdata[3:0];
          end
        end
        ADDR_CNT: begin
          nxt_s.bresp = RESP_OKAY; // Read-only, write ignored
        end
        ADDR_CCR0: begin
          nxt_s.ccr0 = lane_merge(s_ff.ccr0, s_ff.wdata, s_ff.wstrb);
        end
        ADDR_CCR1: begin
          nxt_s.ccr1 = lane_merge(s_ff.ccr1, s_ff.wdata, s_ff.wstrb);
          nxt_s.arm = 1'b1; // set wins over reload clear
        end
        default: begin
          nxt_s.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Read channel
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = RESP_OKAY;
      nxt_s.rdata = 32'h0000_0000;
      case (rd_addr)
        ADDR_CTL0: nxt_s.rdata[7:0] = {s_ff.ce, 4'h0, s_ff.cks};
        ADDR_CTL1: nxt_s.rdata[7:0] = {2'h0, s_ff.eee, 2'h0, s_ff.mode};
        ADDR_IOC0: nxt_s.rdata[3:0] = s_ff.ioc0;
        ADDR_IOC2: nxt_s.rdata[3:0] = s_ff.ioc2;
        ADDR_CNT: nxt_s.rdata[15:0] = s_ff.cnt;
        ADDR_CCR0: nxt_s.rdata[15:0] = s_ff.ccr0;
        ADDR_CCR1: nxt_s.rdata[15:0] = s_ff.ccr1;
        default: nxt_s.rresp = RESP_SLVERR;
      endcase
    end

    // Pins follow the next state so they settle with the counter
    nxt_s.pwm_pin = nxt_s.ioc0[IOC0_OE1_BIT] &
                    (((nxt_s.st == ST_RUN) & (nxt_s.cnt < nxt_s.buf1)) ^
                     nxt_s.ioc0[IOC0_OL1_BIT]);
    nxt_s.sq_pin = nxt_s.ioc0[IOC0_OE0_BIT] ? nxt_s.sq :
                   nxt_s.ioc0[IOC0_OL0_BIT];
  end

  // Single state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= STATE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_idle_rest;
    (s_ff.st != ST_RUN) |-> (s_ff.cnt == CNT_IDLE) && !s_ff.irq0 &&
                            !s_ff.irq1;
  endproperty
  a_idle_rest: assert property (p_idle_rest)
    else $error("counter not idle or irq while stopped");

  property p_first_trigger;
    (s_ff.st == ST_WAIT) && mode_ok && trig |=>
      (s_ff.st == ST_RUN) && (s_ff.cnt == CNT_ZERO);
  endproperty
  a_first_trigger: assert property (p_first_trigger)
    else $error("first trigger did not start counter at zero");

  property p_restart;
    (s_ff.st == ST_RUN) && mode_ok && trig |=> (s_ff.cnt == CNT_ZERO) &&
      (s_ff.sq != $past(s_ff.sq));
  endproperty
  a_restart: assert property (p_restart)
    else $error("running trigger did not restart or toggle");

  property p_period_clear;
    (s_ff.st == ST_RUN) && mode_ok && !trig && tick &&
      (s_ff.cnt == s_ff.buf0) |=> (s_ff.cnt == CNT_ZERO) && s_ff.irq0;
  endproperty
  a_period_clear: assert property (p_period_clear)
    else $error("period match did not clear with irq");

  property p_width_match;
    s_ff.irq1 |-> (s_ff.cnt == s_ff.buf1) && (s_ff.buf1 <= s_ff.buf0);
  endproperty
  a_width_match: assert property (p_width_match)
    else $error("width irq without counter match");

  property p_no_width;
    (s_ff.buf1 > s_ff.buf0) && (s_ff.cnt <= s_ff.buf0) |-> !s_ff.irq1;
  endproperty
  a_no_width: assert property (p_no_width)
    else $error("width irq with width above period");

  // Width pulse and the pin's fall to inactive share one edge
  property p_pwm_level;
    s_ff.irq1 && s_ff.ioc0[IOC0_OE1_BIT] |->
      (pwm_output == s_ff.ioc0[IOC0_OL1_BIT]);
  endproperty
  a_pwm_level: assert property (p_pwm_level)
    else $error("pwm pin not inactive at width match");

  property p_reload_armed;
    (s_ff.st == ST_RUN) && ($past(s_ff.st) == ST_RUN) &&
      ($changed(s_ff.buf0) || $changed(s_ff.buf1)) |-> $past(s_ff.arm);
  endproperty
  a_reload_armed: assert property (p_reload_armed)
    else $error("buffer reloaded without arming write");

  property p_mode_gate;
    (s_ff.st != ST_STOP) |-> $past(s_ff.ce) &&
      ($past(s_ff.mode) == MODE_EXT_TRIG);
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("timer left stop outside triggered mode");

  // A restart never reloads, so a nonzero width keeps output 1 active
  property p_trig_active;
    (s_ff.st == ST_RUN) && mode_ok && trig && (s_ff.buf1 != CNT_ZERO) |=>
      (pwm_output == (s_ff.ioc0[IOC0_OE1_BIT] &
                      !s_ff.ioc0[IOC0_OL1_BIT]));
  endproperty
  a_trig_active: assert property (p_trig_active)
    else $error("trigger did not force pwm pin active");

  property p_square_at_clear;
    s_ff.irq0 |-> (s_ff.sq != $past(s_ff.sq)) && (s_ff.cnt == CNT_ZERO);
  endproperty
  a_square_at_clear: assert property (p_square_at_clear)
    else $error("square state did not toggle at period clear");

  property p_stop_on_disable;
    !s_ff.ce |=> (s_ff.st == ST_STOP);
  endproperty
  a_stop_on_disable: assert property (p_stop_on_disable)
    else $error("timer kept running with count disabled");

  // Without a count clock tick the counter must not move
  property p_hold_without_tick;
    (s_ff.st == ST_RUN) && mode_ok && !trig && !tick |=> $stable(s_ff.cnt);
  endproperty
  a_hold_without_tick: assert property (p_hold_without_tick)
    else $error("counter moved without a count clock tick");

endmodule // triggered_pwm_timer
`default_nettype wire

// ### verification/trig_src.sv
// External trigger source model driving the trigger pin
`timescale 1ns/1ps
`default_nettype none
module trig_src (
  input wire logic aclk,
  input wire logic fire,
  output logic trigger_in
);
  logic [2:0] hold_ff = 3'h0;
  // Pulse held long enough to pass the pin synchroniser
  always @(posedge aclk) begin
    if (fire) begin
      hold_ff <= 3'h7;
    end else if (hold_ff != 3'h0) begin
      hold_ff <= hold_ff - 3'h1;
    end
  end
  // Low between requests, so only a rising edge marks a trigger
  assign trigger_in = (hold_ff != 3'h0);
endmodule // trig_src
`default_nettype wire

// ### verification/tb_triggered_pwm_timer.sv
// Self-checking testbench of the triggered PWM timer
`timescale 1ns/1ps
`default_nettype none
module tb_triggered_pwm_timer;
  import tpwm_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic event_in = 1'b0;
  logic fire = 1'b0;
  logic trigger_in, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, pwm_output, square_wave_output;
  logic period_match_irq, width_match_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int num_errors = 0;
  int total_checks = 0;
  logic [31:0] d;
  logic [1:0] r;
  logic sq0;
  int c0, c1, hi, tg;

  triggered_pwm_timer dut_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .trigger_in(trigger_in),
    .event_in(event_in),
    .pwm_output(pwm_output),
    .square_wave_output(square_wave_output),
    .period_match_irq(period_match_irq),
    .width_match_irq(width_match_irq)
  );
  trig_src src_u (.aclk(aclk), .fire(fire), .trigger_in(trigger_in));

  // Free-running 100 MHz clock
  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic h;
    h = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!h) begin
      @(negedge aclk);
      h = s_axi_arready;
      @(posedge aclk);
      if (h) s_axi_arvalid <= 1'b0;
    end
    h = 1'b0;
    while (!h) begin
      @(negedge aclk);
      h = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (h) s_axi_rready <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axi_wr(a, v);
    chk(32'(r), 32'(RESP_OKAY), "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    chk(32'(r), 32'(RESP_OKAY), "read response");
    chk(d, e, "read data");
  endtask

  // Counts pulses, active cycles and square-wave toggles over n cycles
  task automatic meas(input int n);
    logic sq;
    c0 = 0;
    c1 = 0;
    hi = 0;
    tg = 0;
    @(negedge aclk);
    sq = square_wave_output;
    repeat (n) begin
      @(negedge aclk);
      c0 += int'(period_match_irq);
      c1 += int'(width_match_irq);
      hi += int'(pwm_output);
      tg += int'(square_wave_output != sq);
      sq = square_wave_output;
    end
  endtask

  task automatic run_chk(input int n, input int e0, input int e1,
                         input int eh, input int et);
    meas(n);
    chk(32'(c0), 32'(e0), "period pulses");
    chk(32'(c1), 32'(e1), "width pulses");
    chk(32'(hi), 32'(eh), "active cycles");
    chk(32'(tg), 32'(et), "square toggles");
  endtask

  // Watchdog more than ten times the cycles the tests need
  initial begin
    wt(20000);
    num_errors++;
    $display("unexpected at %0t: timeout", $time);
    end_sim();
  end

  initial begin
    wt(5);
    aresetn <= 1'b1;
    rd(ADDR_CNT, 32'h0000_ffff);
    rd(ADDR_CCR0, 32'h0000_0000);
    axi_rd(8'h1c);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped read");
    axi_wr(8'h20, 32'h0000_0001);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped write");
    $display("test reset done");
    // Period 5 counts, active width 2, both outputs on
    wr(ADDR_IOC0, 32'h0000_0005);
    wr(ADDR_IOC2, 32'h0000_0001);
    wr(ADDR_CCR0, 32'h0000_0004);
    wr(ADDR_CCR1, 32'h0000_0002);
    wr(ADDR_CTL1, 32'(MODE_EXT_TRIG));
    wr(ADDR_CTL0, 32'h0000_0080);
    run_chk(20, 0, 0, 0, 0);
    rd(ADDR_CNT, 32'h0000_ffff);
    wr(ADDR_CTL1, 32'h0000_0042);
    wt(10);
    run_chk(25, 5, 5, 10, 5);
    rd(ADDR_CTL1, 32'(MODE_EXT_TRIG));
    $display("test software trigger done");
    wr(ADDR_CCR1, 32'h0000_0000);
    wt(15);
    meas(25);
    chk(32'(hi), 32'h0000_0000, "zero duty");
    wr(ADDR_CCR1, 32'h0000_0005);
    wt(15);
    run_chk(25, 5, 0, 25, 5);
    $display("test duty limits done");
    // A period write alone must not reach the buffers
    wr(ADDR_CCR0, 32'h0000_0009);
    wt(20);
    meas(25);
    chk(32'(c0), 32'h0000_0005, "period unchanged");
    wr(ADDR_CCR1, 32'h0000_0003);
    wt(25);
    run_chk(30, 3, 3, 9, 3);
    $display("test buffer reload done");
    wr(ADDR_IOC0, 32'h0000_000d);
    run_chk(30, 3, 3, 21, 3);
    wr(ADDR_IOC0, 32'h0000_0006);
    run_chk(30, 3, 3, 9, 0);
    chk(32'(square_wave_output), 32'h0000_0001, "idle level");
    $display("test output control done");
    // Long period so a restart stands out from a natural clear
    wr(ADDR_IOC0, 32'h0000_0005);
    wr(ADDR_CCR0, 32'h0000_00ff);
    wr(ADDR_CCR1, 32'h0000_0040);
    wt(300);
    for (int i = 0; i < 400 && period_match_irq !== 1'b1; i++) begin
      @(negedge aclk);
    end
    wt(100);
    sq0 = square_wave_output;
    fire <= 1'b1;
    wt(1);
    fire <= 1'b0;
    wt(10);
    // Look mid-cycle, away from the edge that launches the pins
    @(negedge aclk);
    chk(32'(square_wave_output), 32'(!sq0), "square inverted");
    chk(32'(pwm_output), 32'h0000_0001, "pwm forced active");
    axi_rd(ADDR_CNT);
    chk(32'(d < 32'h0000_0020), 32'h0000_0001, "restart");
    $display("test external trigger done");
    wr(ADDR_CTL0, 32'h0000_0000);
    wt(5);
    run_chk(30, 0, 0, 0, 0);
    rd(ADDR_CNT, 32'h0000_ffff);
    $display("test stop done");
    // Halved count clock: period 8 cycles, active width 2 cycles
    wr(ADDR_CCR0, 32'h0000_0003);
    wr(ADDR_CCR1, 32'h0000_0001);
    wr(ADDR_CTL0, 32'h0000_0081);
    wr(ADDR_CTL1, 32'h0000_0042);
    wt(20);
    run_chk(40, 5, 5, 10, 5);
    // Event clock: the counter moves only on event pin edges
    wr(ADDR_IOC2, 32'h0000_0005);
    wr(ADDR_CTL1, 32'h0000_0062);
    wt(10);
    rd(ADDR_CNT, 32'h0000_0000);
    repeat (3) begin
      event_in <= 1'b1;
      wt(3);
      event_in <= 1'b0;
      wt(3);
    end
    wt(5);
    rd(ADDR_CNT, 32'h0000_0003);
    $display("test count clock done");
    // Reset while running brings registers and counter back to rest
    aresetn <= 1'b0;
    wt(5);
    aresetn <= 1'b1;
    rd(ADDR_CTL1, 32'h0000_0000);
    rd(ADDR_CNT, 32'h0000_ffff);
    chk(32'(pwm_output), 32'h0000_0000, "pwm after reset");
    $display("test mid-run reset done");
    end_sim();
  end
endmodule // tb_triggered_pwm_timer
`default_nettype wire
